// ### design/rtcta_regs.vh
// Register map, field positions, reset values and timing figures of the tick/alarm counter.
// Assumes inclusion by the counter core only; definitions only.
`ifndef RTCTA_REGS_VH
`define RTCTA_REGS_VH

// ==========================================
// Register byte offsets
`define RTCTA_OFS_CONTROL       8'h00
`define RTCTA_OFS_SRC_SELECT    8'h04
`define RTCTA_OFS_IRQ_ENABLE    8'h08
`define RTCTA_OFS_RAW_STATUS    8'h0C
`define RTCTA_OFS_IRQ_CLEAR     8'h10
`define RTCTA_OFS_TICK_RELOAD   8'h14
`define RTCTA_OFS_TICK_COUNT    8'h18
`define RTCTA_OFS_ALARM_RELOAD  8'h1C
`define RTCTA_OFS_ALARM_COUNT   8'h20

// ==========================================
// Field positions
`define RTCTA_BIT_RUN_ON        0
`define RTCTA_BIT_TICK          0
`define RTCTA_BIT_ALARM         1
`define RTCTA_BIT_WRAP          2
`define RTCTA_TICK_RELOAD_MSB   19

// ==========================================
// Source select codes
`define RTCTA_SRC_INT_SLOW      2'h0
`define RTCTA_SRC_EXT_SLOW      2'h1
`define RTCTA_SRC_RESERVED      2'h2
`define RTCTA_SRC_EXT_FAST      2'h3

// ==========================================
// Reset values and alarm counter maximum
`define RTCTA_RST_TICK_RELOAD   20'h08000
`define RTCTA_RST_ALARM_RELOAD  32'h0FFFFFFF
`define RTCTA_ALARM_MAX         32'h0FFFFFFF

// ==========================================
// Timing: fast crystal divide ratio
`define RTCTA_FAST_DIVIDE       128

`endif

// ### design/rtcta_core.v
// Tick/alarm real-time counter with an APB register slave.
// Assumes pclk at 200 MHz; the three source clocks are asynchronous pins far slower
// than pclk, so each is synchronised and edge-detected in the pclk domain.
// Writes to the read-only words are ignored; unmapped offsets answer with pslverr.
// The reserved source code leaves both counters standing.
//
// Overview of operation
// [R1] Enabling clears both counters and starts counting.
// [R2] Software sets enable last in setup.
// [R3] Software disables before changing clock source.
// [R4] Source code picks slow, crystal, or fast/128.
// [R5] Changing source clears both counters.
// [R6] Enable register holds wrap, alarm, tick enables.
// [R7] Request raised per set flag when enabled.
// [R8] Wrap flag set on alarm counter rollover.
// [R9] Alarm flag set when alarm count matches reload.
// [R10] Tick flag set when tick count matches reload.
// [R11] Flags read-only; write one clears flag.
// [R12] Tick reload 20 bits, writes clear both counters.
// [R13] Zero tick reload stored as default.
// [R14] Tick counter readable, resets to zero.
// [R15] Alarm reload writable; write clears alarm counter.
// [R16] Zero alarm reload stored as default.
// [R17] Alarm counter readable, resets to zero.
// [R18] Alarm counter advances once per tick period.
// [R19] Tick flag rises before the count update.
// [R20] Tick counter wraps at reload, emits tick.
// [R21] While disabled counters hold, no flags set.
`timescale 1ns/10ps
`include "rtcta_regs.vh"

module rtcta_core #(
	parameter FAST_DIV = `RTCTA_FAST_DIVIDE
) (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB register port
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output wire [31:0] prdata,
	// Asynchronous source clock pins
	input  wire        int_slow_osc_clk,
	input  wire        ext_slow_xtal_clk,
	input  wire        ext_fast_xtal_clk,
	// Event outputs
	output wire [2:0]  irq_req,
	output wire        tick_pulse
);

	// ==========================================
	// Local helpers

	// Address lies on one of the mapped words
	function rtcta_mapped;
		input [7:0] a;
		begin
			rtcta_mapped = (a[1:0] == 2'h0) && (a <= `RTCTA_OFS_ALARM_COUNT);
		end
	endfunction

	// Access phase of a transfer to one given register offset
	function rtcta_hit;
		input       acc;
		input [7:0] a;
		input [7:0] ofs;
		begin
			rtcta_hit = acc && (a == ofs);
		end
	endfunction

	// Alarm counter sits on its last value before rolling over
	function rtcta_at_max;
		input [31:0] cnt;
		begin
			rtcta_at_max = (cnt == `RTCTA_ALARM_MAX);
		end
	endfunction

	// Last prescaler state, cut to the counter width on purpose
	localparam integer FAST_DIV_LAST_INT = FAST_DIV - 1;
	localparam [7:0]   FAST_DIV_LAST     = FAST_DIV_LAST_INT[7:0];

	// ==========================================
	// Declarations
	reg  [2:0]  sync_a_ff;
	reg  [2:0]  sync_b_ff;
	reg  [2:0]  sync_prev_ff;
	reg  [7:0]  fast_div_ff;
	reg         run_on_ff;
	reg  [1:0]  source_pick_ff;
	reg  [2:0]  irq_on_ff;
	reg  [2:0]  raw_flag_ff;
	reg  [19:0] tick_reload_ff;
	reg  [31:0] alarm_reload_ff;
	reg  [31:0] tick_counter_ff;
	reg  [31:0] alarm_counter_ff;
	reg  [31:0] prdata_ff;
	reg         tick_pulse_ff;
	reg  [31:0] nxt_prdata;
	reg  [2:0]  nxt_raw_flag;
	reg  [31:0] nxt_tick_counter;
	reg  [31:0] nxt_alarm_counter;
	reg         nxt_tick_pulse;
	reg         src_edge;
	wire [2:0]  rise;
	wire        fast_edge;
	wire        setup_ph;
	wire        wr_acc;
	wire        wr_ctrl;
	wire        wr_src;
	wire        wr_treload;
	wire        wr_areload;
	wire        wr_clear;
	wire        wr_ienable;
	wire        start_run;
	wire        src_change;
	wire        clr_both;
	wire        clr_alarm;
	wire        tick_match;
	wire        alarm_match;
	wire        alarm_at_max;

	// ==========================================
	// Source clock synchronisers and edge detection

	// Two flops per source pin; nothing else reads the first stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a_ff <= 3'h0;
			sync_b_ff <= 3'h0;
		end else begin
			sync_a_ff <= {ext_fast_xtal_clk, ext_slow_xtal_clk, int_slow_osc_clk};
			sync_b_ff <= sync_a_ff;
		end
	end

	// History of the second stage for rising edge detection
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_prev_ff <= 3'h0;
		end else begin
			sync_prev_ff <= sync_b_ff;
		end
	end

	assign rise = sync_b_ff & ~sync_prev_ff;

	// Fast crystal prescaler: one enable every FAST_DIV rising edges
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_div_ff <= 8'h00;
		end else if (rise[2]) begin
			fast_div_ff <= (fast_div_ff == FAST_DIV_LAST) ? 8'h00 : fast_div_ff + 8'h01;
		end
	end

	assign fast_edge = rise[2] && (fast_div_ff == FAST_DIV_LAST);

	// Selected counting edge; the reserved code never counts
	always @* begin
		case (source_pick_ff)
			`RTCTA_SRC_INT_SLOW: src_edge = rise[0];   // [R4]
			`RTCTA_SRC_EXT_SLOW: src_edge = rise[1];   // [R4]
			`RTCTA_SRC_EXT_FAST: src_edge = fast_edge; // [R4]
			default:             src_edge = 1'b0;
		endcase
	end

	// ==========================================
	// APB slave decode

	// One wait-free access phase; read data captured in the setup cycle
	assign setup_ph   = psel && !penable;
	assign pready     = psel && penable;
	assign pslverr    = psel && penable && !rtcta_mapped(paddr);
	assign wr_acc     = psel && penable && pwrite;
	assign wr_ctrl    = rtcta_hit(wr_acc, paddr, `RTCTA_OFS_CONTROL);
	assign wr_src     = rtcta_hit(wr_acc, paddr, `RTCTA_OFS_SRC_SELECT);
	assign wr_ienable = rtcta_hit(wr_acc, paddr, `RTCTA_OFS_IRQ_ENABLE);
	assign wr_treload = rtcta_hit(wr_acc, paddr, `RTCTA_OFS_TICK_RELOAD);
	assign wr_areload = rtcta_hit(wr_acc, paddr, `RTCTA_OFS_ALARM_RELOAD);
	assign wr_clear   = rtcta_hit(wr_acc, paddr, `RTCTA_OFS_IRQ_CLEAR);
	assign prdata     = prdata_ff;

	// Counter clear causes
	assign start_run  = wr_ctrl && pwdata[`RTCTA_BIT_RUN_ON] && !run_on_ff;          // [R1]
	assign src_change = wr_src && (pwdata[1:0] != source_pick_ff);                   // [R5]
	assign clr_both   = start_run || src_change || wr_treload;                       // [R12]
	assign clr_alarm  = clr_both || wr_areload;                                       // [R15]

	// Read multiplexer
	always @* begin
		nxt_prdata = 32'h00000000;
		case (paddr)
			`RTCTA_OFS_CONTROL:      nxt_prdata = {31'h00000000, run_on_ff};
			`RTCTA_OFS_SRC_SELECT:   nxt_prdata = {30'h00000000, source_pick_ff};
			`RTCTA_OFS_IRQ_ENABLE:   nxt_prdata = {29'h00000000, irq_on_ff};
			`RTCTA_OFS_RAW_STATUS:   nxt_prdata = {29'h00000000, raw_flag_ff};
			`RTCTA_OFS_TICK_RELOAD:  nxt_prdata = {12'h000, tick_reload_ff};
			`RTCTA_OFS_TICK_COUNT:   nxt_prdata = tick_counter_ff;                    // [R14]
			`RTCTA_OFS_ALARM_RELOAD: nxt_prdata = alarm_reload_ff;
			`RTCTA_OFS_ALARM_COUNT:  nxt_prdata = alarm_counter_ff;                   // [R17]
			default:                 nxt_prdata = 32'h00000000;
		endcase
	end

	// Read data register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h00000000;
		end else if (setup_ph && !pwrite) begin
			prdata_ff <= nxt_prdata;
		end
	end

	// ==========================================
	// Configuration registers

	// Run control bit; the clear on a 0 to 1 write lives in the counter logic
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_on_ff <= 1'b0;
		end else if (wr_ctrl) begin
			run_on_ff <= pwdata[`RTCTA_BIT_RUN_ON];
		end
	end

	// Source select; a change of code clears both counters below
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_pick_ff <= `RTCTA_SRC_INT_SLOW;
		end else if (wr_src) begin
			source_pick_ff <= pwdata[1:0]; // [R4]
		end
	end

	// Request enables, one bit per event
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_on_ff <= 3'h0;
		end else if (wr_ienable) begin
			irq_on_ff <= pwdata[2:0]; // [R6]
		end
	end

	// Reload values; a zero write takes the default so counting never stalls
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_reload_ff  <= `RTCTA_RST_TICK_RELOAD;
			alarm_reload_ff <= `RTCTA_RST_ALARM_RELOAD;
		end else begin
			if (wr_treload) begin
				tick_reload_ff <= (pwdata[19:0] == 20'h00000) ? `RTCTA_RST_TICK_RELOAD
				                                              : pwdata[19:0];        // [R13]
			end
			if (wr_areload) begin
				alarm_reload_ff <= (pwdata == 32'h00000000) ? `RTCTA_RST_ALARM_RELOAD
				                                            : pwdata;               // [R16]
			end
		end
	end

	// ==========================================
	// Counters and flags

	assign tick_match  = (tick_counter_ff == {12'h000, tick_reload_ff});
	assign alarm_match = (alarm_counter_ff == alarm_reload_ff);
	assign alarm_at_max = rtcta_at_max(alarm_counter_ff);

	// Next counter values: count source edges only while running
	always @* begin
		nxt_tick_counter  = tick_counter_ff;
		nxt_alarm_counter = alarm_counter_ff;
		nxt_tick_pulse    = 1'b0;
		if (run_on_ff && src_edge) begin                                              // [R21]
			if (tick_match) begin
				nxt_tick_counter = 32'h00000000;                                      // [R20]
				nxt_tick_pulse   = 1'b1;
				if (alarm_at_max) begin
					nxt_alarm_counter = 32'h00000000;                                 // [R8]
				end else begin
					nxt_alarm_counter = alarm_counter_ff + 32'h00000001;              // [R18]
				end
			end else begin
				nxt_tick_counter = tick_counter_ff + 32'h00000001;                    // [R20]
			end
		end
		if (clr_both) begin
			nxt_tick_counter = 32'h00000000;                                          // [R1] [R5]
		end
		if (clr_alarm) begin
			nxt_alarm_counter = 32'h00000000;                                         // [R12] [R15]
		end
	end

	// Flags: write-one clear, but a same-cycle set wins
	always @* begin
		nxt_raw_flag = raw_flag_ff;
		if (wr_clear) begin
			nxt_raw_flag = raw_flag_ff & ~pwdata[2:0];                                // [R11]
		end
		if (run_on_ff) begin                                                          // [R21]
			if (tick_match) begin
				nxt_raw_flag[`RTCTA_BIT_TICK] = 1'b1;                                 // [R10] [R19]
			end
			if (alarm_match) begin
				nxt_raw_flag[`RTCTA_BIT_ALARM] = 1'b1;                                // [R9]
			end
			if (src_edge && tick_match && alarm_at_max) begin
				nxt_raw_flag[`RTCTA_BIT_WRAP] = 1'b1;                                 // [R8]
			end
		end
	end

	// Counter state
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_counter_ff  <= 32'h00000000;                                         // [R14]
			alarm_counter_ff <= 32'h00000000;                                         // [R17]
		end else begin
			tick_counter_ff  <= nxt_tick_counter;
			alarm_counter_ff <= nxt_alarm_counter;
		end
	end

	// Sticky flag and tick pulse state
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_flag_ff   <= 3'h0;
			tick_pulse_ff <= 1'b0;
		end else begin
			raw_flag_ff   <= nxt_raw_flag;
			tick_pulse_ff <= nxt_tick_pulse;
		end
	end

	// Request lines: each flag gated by its own enable
	assign irq_req    = raw_flag_ff & irq_on_ff;                                      // [R7]
	assign tick_pulse = tick_pulse_ff;

endmodule

// ### verification/rtcta_checker.sv
// Checker for the tick/alarm counter, watching only the core's ports.
// Assumes binding to rtcta_core; shadows of enables and source follow APB writes.
`timescale 1ns/10ps
module rtcta_checker #(
	parameter FAST_DIV = 128
) (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	input wire        pslverr,
	input wire [31:0] prdata,
	input wire        int_slow_osc_clk,
	input wire        ext_slow_xtal_clk,
	input wire        ext_fast_xtal_clk,
	input wire [2:0]  irq_req,
	input wire        tick_pulse
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire       acc = psel && penable;
	wire       wr  = acc && pwrite;
	wire       rd  = acc && !pwrite;
	reg  [2:0] ie_ff;
	reg        run_ff;
	reg  [1:0] src_ff;
	// ==========================================
	// Shadows of the writable controls
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ie_ff  <= 3'h0;
			run_ff <= 1'b0;
			src_ff <= 2'h0;
		end else if (wr) begin
			if (paddr == 8'h08) ie_ff <= pwdata[2:0];
			if (paddr == 8'h00) run_ff <= pwdata[0];
			if (paddr == 8'h04) src_ff <= pwdata[1:0];
		end
	end
	// ==========================================
	// Properties
	a_irq_gated_enable: assert property ((irq_req & ~ie_ff) == 3'h0)
		else $error("request without its enable");
	a_irq_keep_flags: assert property (wr && paddr == 8'h08 && pwdata[2:0] == 3'h7
		|=> (irq_req & $past(irq_req)) == $past(irq_req))
		else $error("enabling all lost a request");
	a_pulse_single: assert property (tick_pulse |=> !tick_pulse [*8])
		else $error("tick pulse too long or too close");
	a_flag_before_tick: assert property (tick_pulse && ie_ff[0] |-> $past(irq_req[0]))
		else $error("tick flag not ahead of count wrap");
	a_wrap_clear_one: assert property (wr && paddr == 8'h10 && pwdata[2]
		|=> !irq_req[2] || tick_pulse)
		else $error("wrap flag survived clear");
	a_idle_no_tick: assert property (!run_ff && !$past(run_ff) |-> !tick_pulse)
		else $error("tick while disabled");
	a_reserved_no_tick: assert property (src_ff == 2'h2 && $past(src_ff) == 2'h2
		|-> !tick_pulse)
		else $error("reserved source counted");
	a_clear_reads_zero: assert property (rd && paddr == 8'h10 |-> prdata == 32'h0)
		else $error("clear register read nonzero");
	a_tick_reload_rd: assert property (rd && paddr == 8'h14
		|-> prdata[31:20] == 12'h000 && prdata[19:0] != 20'h00000)
		else $error("tick reload out of range");
endmodule

// ### verification/testbench.sv
// Self-checking bench for the tick/alarm counter over APB.
// Assumes rtcta_core with FAST_DIV 4; all source pins share one clock of 8 pclk periods.
`timescale 1ns/10ps
module testbench;
	typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} rtcta_row_t;
	reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0;
	reg  [2:0]  div = 3'h0;
	wire        pready, pslverr, tick_pulse;
	wire [31:0] prdata;
	wire [2:0]  irq_req;
	int         err_total = 0, total_checks = 0, pcnt = 0, n, i;
	logic [31:0] v, w;
	logic        perr = 1'b0;
	rtcta_row_t rows [15] = '{
		'{8'h00,0,0,0}, '{8'h04,0,0,0}, '{8'h08,0,0,0}, '{8'h0C,0,0,0}, '{8'h10,0,0,0},
		'{8'h14,0,0,32'h8000}, '{8'h18,0,0,0}, '{8'h1C,0,0,32'h0FFFFFFF}, '{8'h20,0,0,0},
		'{8'h08,1,32'hFFFFFFFF,7}, '{8'h14,1,0,32'h8000}, '{8'h14,1,32'hFFFFFFFF,32'hFFFFF},
		'{8'h1C,1,0,32'h0FFFFFFF}, '{8'h0C,1,32'hFF,0}, '{8'h24,0,0,0}};
	// Clock, shared source clock and pulse counter
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) div <= div + 3'h1;
	always @(posedge pclk) if (tick_pulse === 1'b1) pcnt++;
	rtcta_core #(.FAST_DIV(4)) u_rtcta_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .int_slow_osc_clk(div[2]),
		.ext_slow_xtal_clk(div[2]), .ext_fast_xtal_clk(div[2]), .irq_req(irq_req),
		.tick_pulse(tick_pulse));
	// ==========================================
	// Tasks
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task apb(input logic wrt, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= wrt; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
		q = prdata;
		perr = pslverr;
		if (k >= 50) begin err_total++; give_verdict(); end
		psel <= 0; penable <= 0;
	endtask
	task wp(output int c);
		c = 0;
		do begin @(posedge pclk); c++; end while (tick_pulse !== 1'b1 && c < 2000);
		if (c >= 2000) begin err_total++; give_verdict(); end
	endtask
	task measure(input int e);
		wp(n); wp(n);
		chk("tick period", e, n);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		for (i = 0; i < 15; i++) begin
			if (rows[i].w) apb(1, rows[i].a, rows[i].d, v);
			apb(0, rows[i].a, 0, v);
			chk("row", rows[i].e, v);
			chk("slave error", rows[i].a > 8'h20, perr);
		end
		$display("test done: register table");
		apb(1, 8'h14, 3, v); apb(1, 8'h1C, 2, v); pcnt = 0;
		apb(1, 8'h00, 1, v);
		measure(32);
		wp(n);
		apb(1, 8'h00, 0, v); repeat (10) @(posedge pclk);
		apb(0, 8'h20, 0, v); chk("alarm count", pcnt, v);
		apb(0, 8'h0C, 0, v); chk("raw status", 3, v);
		chk("irq", 3, irq_req);
		apb(0, 8'h18, 0, v); repeat (50) @(posedge pclk);
		apb(0, 8'h18, 0, w); chk("held count", v, w);
		apb(1, 8'h10, 0, v); apb(0, 8'h0C, 0, v); chk("clear zero", 3, v);
		apb(1, 8'h10, 6, v); apb(0, 8'h0C, 0, v); chk("clear alarm", 1, v);
		$display("test done: counting and flags");
		apb(1, 8'h00, 1, v); apb(0, 8'h20, 0, v); chk("enable clears", 0, v);
		wp(n); apb(1, 8'h1C, 5, v); apb(0, 8'h20, 0, v); chk("alarm reload", 0, v);
		wp(n); apb(1, 8'h14, 3, v); apb(0, 8'h20, 0, v); chk("tick reload", 0, v);
		wp(n); apb(1, 8'h00, 0, v); apb(1, 8'h04, 3, v);
		apb(0, 8'h18, 0, v); chk("src tick", 0, v);
		apb(0, 8'h20, 0, v); chk("src alarm", 0, v);
		apb(1, 8'h14, 1, v); apb(1, 8'h00, 1, v);
		measure(64);
		apb(1, 8'h00, 0, v); apb(1, 8'h04, 2, v); apb(1, 8'h00, 1, v);
		pcnt = 0; repeat (200) @(posedge pclk);
		chk("reserved source", 0, pcnt);
		$display("test done: sources and clears");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h14, 0, v); chk("reset reload", 32'h8000, v);
		apb(0, 8'h18, 0, v); chk("reset count", 0, v);
		$display("test done: reset in mid-run");
		give_verdict();
	end
endmodule
bind rtcta_core rtcta_checker #(.FAST_DIV(FAST_DIV)) u_rtcta_checker (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.int_slow_osc_clk(int_slow_osc_clk), .ext_slow_xtal_clk(ext_slow_xtal_clk),
	.ext_fast_xtal_clk(ext_fast_xtal_clk), .irq_req(irq_req), .tick_pulse(tick_pulse));
